//--- cmr_pkg.sv
// Constants, field layout and state type of the receive mailbox block
// Assumes one core clock; every offset is a byte address on the plain port
package cmr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int ID_W   = 29;
  localparam int LEN_W  = 4;
  localparam int TS_W   = 16;
  localparam int PAY_W  = 64;

  // Register offsets
  localparam logic [ADDR_W-1:0] MCR_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] FRT_OFS   = 12'h008;
  localparam logic [ADDR_W-1:0] MASK_OFS  = 12'h010;
  localparam logic [ADDR_W-1:0] FLAG_OFS  = 12'h020;
  localparam logic [ADDR_W-1:0] IMASK_OFS = 12'h028;
  localparam logic [ADDR_W-1:0] SLOT_BASE = 12'h080;
  localparam int                SLOT_SH   = 4;

  // Word select inside a mailbox slot
  localparam logic [1:0] WD_CS = 2'h0;
  localparam logic [1:0] WD_ID = 2'h1;
  localparam logic [1:0] WD_D0 = 2'h2;
  localparam logic [1:0] WD_D1 = 2'h3;

  // Configuration bits
  localparam int MCR_SRX_BIT = 0;
  localparam int MCR_RXQ_BIT = 1;
  localparam int MCR_FRZ_BIT = 2;
  localparam int RXQ_FLAG_BIT = 5;

  // Control/status word layout
  localparam int CS_CODE_LSB = 24;
  localparam int CS_LEN_LSB  = 16;

  // Codes
  localparam logic [3:0] CODE_RX_INACTIVE = 4'h0;
  localparam logic [3:0] CODE_RX_EMPTY    = 4'h4;
  localparam logic [3:0] CODE_RX_FULL     = 4'h2;
  localparam logic [3:0] CODE_RX_OVERRUN  = 4'h6;
  localparam logic [3:0] CODE_TX_INACTIVE = 4'h8;
  localparam logic [3:0] CODE_TX_DATA     = 4'hC;
  localparam logic [3:0] CODE_BUSY        = 4'h1;

  // Reset values
  localparam logic [2:0]      MCR_RST  = 3'h4;
  localparam logic [ID_W-1:0] MASK_RST = 29'h1FFF_FFFF;

  // Move-in length in core cycles
  localparam int MOVE_CYC_DEF = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RSCAN = 3'b001,
    ST_RWAIT = 3'b010,
    ST_MOVE  = 3'b011,
    ST_TSCAN = 3'b100,
    ST_TOUT  = 3'b101
  } cmr_state_t;

endpackage

//--- cmr_lock_ctl.sv
// Single-entry read lock of the receive mailboxes
// Assumes strobes from the core clock domain, one access per cycle
`timescale 1ns/10ps
module cmr_lock_ctl #(
  parameter int IDXW = 4
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            cs_rd_i,
  input  wire logic [IDXW-1:0] rd_idx_i,
  input  wire logic            lockable_i,
  input  wire logic            frt_rd_i,
  input  wire logic            cs_wr_i,
  input  wire logic [IDXW-1:0] wr_idx_i,
  output logic                 lock_vld_o,
  output logic      [IDXW-1:0] lock_idx_o
);
  logic            lock_vld_ff;
  logic            nxt_lock_vld;
  logic [IDXW-1:0] lock_idx_ff;
  logic [IDXW-1:0] nxt_lock_idx;

  always_comb begin
    nxt_lock_vld = lock_vld_ff;
    nxt_lock_idx = lock_idx_ff;
    if (frt_rd_i) begin
      nxt_lock_vld = 1'b0;
    end
    if (cs_rd_i) begin
      if (lockable_i) begin
        nxt_lock_vld = 1'b1;
        nxt_lock_idx = rd_idx_i;
      end else if (rd_idx_i != lock_idx_ff) begin
        nxt_lock_vld = 1'b0;
      end
    end
    if (cs_wr_i && (wr_idx_i == lock_idx_ff)) begin
      nxt_lock_vld = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_vld_ff <= 1'b0;
      lock_idx_ff <= '0;
    end else begin
      lock_vld_ff <= nxt_lock_vld;
      lock_idx_ff <= nxt_lock_idx;
    end
  end

  assign lock_vld_o = lock_vld_ff;
  assign lock_idx_o = lock_idx_ff;

endmodule

//--- cmr_mailbox_rx.sv
// Mailbox array, receive matching, move-in, lock and deactivation handling
// Assumes a protocol engine on the same clock and a one-cycle register port
`timescale 1ns/10ps

// Behaviour
// - Completed reception stores free-running timer value
// - Reception stores ID, length, eight payload bytes
// - Reception updates code, sets flag, masked interrupt
// - Status read of full slot locks it
// - Timer read or other status read unlocks
// - Only one slot locked at once
// - Only active non-empty receive slots lock
// - Busy bit shown while frame moves in
// - Busy or empty status read never locks
// - Frame for locked slot waits in staging
// - Newer frame silently replaces waiting staged frame
// - Received identifier always overwrites stored ID
// - Own frames dropped when self reception disabled
// - Code stays full after service and unlock
// - Status write excludes slot from current round
// - Single-pass match; deactivated candidate invalid, continue
// - Deactivated transmit winner replaced from unscanned only
// - Late transmit deactivation: sent, no flag/update
// - Deactivation clears lock, cancels pending move-in
// - Queue enable only in freeze; flag clear pops
// - Codes 0000, 1000, 1001 take no part
module cmr_mailbox_rx
  import cmr_pkg::*;
#(
  parameter int NUM_MB   = 16,
  parameter int MOVE_CYC = cmr_pkg::MOVE_CYC_DEF
) (
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RST_I,
  input  wire logic [cmr_pkg::ADDR_W-1:0]   ADDR_I,
  input  wire logic [cmr_pkg::DATA_W-1:0]   WR_DATA_I,
  input  wire logic                         WR_I,
  input  wire logic                         RD_I,
  output logic      [cmr_pkg::DATA_W-1:0]   RD_DATA_O,
  input  wire logic                         RX_VALID_I,
  input  wire logic [cmr_pkg::ID_W-1:0]     RX_ID_I,
  input  wire logic [cmr_pkg::LEN_W-1:0]    RX_LEN_I,
  input  wire logic [cmr_pkg::PAY_W-1:0]    RX_DATA_I,
  input  wire logic                         RX_SELF_I,
  input  wire logic                         TX_REQ_I,
  input  wire logic                         TX_DONE_I,
  output logic                              TX_VALID_O,
  output logic      [cmr_pkg::ID_W-1:0]     TX_ID_O,
  output logic      [cmr_pkg::LEN_W-1:0]    TX_LEN_O,
  output logic      [cmr_pkg::PAY_W-1:0]    TX_DATA_O,
  output logic                              IRQ_O,
  output logic                              RXQ_EN_O,
  output logic                              RXQ_POP_O
);
  import cmr_pkg::*;

  localparam int IDXW = $clog2(NUM_MB);

  function automatic logic rx_active(input logic [3:0] c);
    return (c[3] == 1'b0) && (c != CODE_RX_INACTIVE);
  endfunction

  function automatic logic tx_active(input logic [3:0] c);
    return c == CODE_TX_DATA;
  endfunction

  // Slot storage
  logic [3:0]       code_ff [NUM_MB];
  logic [3:0]       nxt_code [NUM_MB];
  logic [LEN_W-1:0] len_ff [NUM_MB];
  logic [LEN_W-1:0] nxt_len [NUM_MB];
  logic [TS_W-1:0]  ts_ff [NUM_MB];
  logic [TS_W-1:0]  nxt_ts [NUM_MB];
  logic [ID_W-1:0]  id_ff [NUM_MB];
  logic [ID_W-1:0]  nxt_id [NUM_MB];
  logic [PAY_W-1:0] pay_ff [NUM_MB];
  logic [PAY_W-1:0] nxt_pay [NUM_MB];

  // Scan engine
  cmr_state_t       state_ff;
  cmr_state_t       nxt_state;
  logic [IDXW-1:0]  idx_ff;
  logic [IDXW-1:0]  nxt_idx;
  logic [IDXW-1:0]  cand_ff;
  logic [IDXW-1:0]  nxt_cand;
  logic             cand_vld_ff;
  logic             nxt_cand_vld;
  logic             cand_free_ff;
  logic             nxt_cand_free;
  logic [3:0]       cnt_ff;
  logic [3:0]       nxt_cnt;
  logic [NUM_MB-1:0] deact_ff;
  logic [NUM_MB-1:0] nxt_deact;
  logic [ID_W-1:0]  stg_id_ff;
  logic [ID_W-1:0]  nxt_stg_id;
  logic [LEN_W-1:0] stg_len_ff;
  logic [LEN_W-1:0] nxt_stg_len;
  logic [PAY_W-1:0] stg_pay_ff;
  logic [PAY_W-1:0] nxt_stg_pay;
  logic             tx_vld_ff;
  logic             nxt_tx_vld;
  logic             tx_late_ff;
  logic             nxt_tx_late;
  logic [NUM_MB-1:0] flag_set;

  // Configuration and status
  logic [2:0]        mcr_ff;
  logic [2:0]        nxt_mcr;
  logic [ID_W-1:0]   mask_ff;
  logic [ID_W-1:0]   nxt_mask;
  logic [TS_W-1:0]   frt_ff;
  logic [NUM_MB-1:0] flag_ff;
  logic [NUM_MB-1:0] nxt_flag;
  logic [NUM_MB-1:0] imask_ff;
  logic [NUM_MB-1:0] nxt_imask;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic              irq_ff;
  logic              pop_ff;
  logic              nxt_pop;

  // Access decode
  logic [ADDR_W-1:0] slot_off;
  logic              in_slot;
  logic [IDXW-1:0]   acc_idx;
  logic              cs_wr;
  logic              cs_rd;
  logic              frt_rd;
  logic [NUM_MB-1:0] wr_hot;
  logic [NUM_MB-1:0] dv;
  logic [3:0]        acc_code;
  logic              lockable;
  logic              lock_vld;
  logic [IDXW-1:0]   lock_idx;
  logic              scan_hit;
  logic              scan_last;

  assign slot_off  = ADDR_I - SLOT_BASE;
  assign in_slot   = (ADDR_I >= SLOT_BASE) && (slot_off[ADDR_W-1:SLOT_SH] < 8'(NUM_MB));
  assign acc_idx   = slot_off[SLOT_SH +: IDXW];
  assign cs_wr     = WR_I && in_slot && (ADDR_I[3:2] == WD_CS);
  assign cs_rd     = RD_I && in_slot && (ADDR_I[3:2] == WD_CS);
  assign frt_rd    = RD_I && (ADDR_I == FRT_OFS);
  assign wr_hot    = cs_wr ? (NUM_MB'(1) << acc_idx) : '0;
  assign dv        = deact_ff | wr_hot;
  assign acc_code  = code_ff[acc_idx] | ((state_ff == ST_MOVE && cand_ff == acc_idx) ?
                     CODE_BUSY : 4'h0);
  assign lockable  = rx_active(acc_code) && (acc_code != CODE_RX_EMPTY)
                     && !acc_code[0];
  assign scan_last = idx_ff == IDXW'(NUM_MB - 1);
  assign scan_hit  = rx_active(code_ff[idx_ff]) && !dv[idx_ff]
                     && (((id_ff[idx_ff] ^ stg_id_ff) & mask_ff) == '0);

  cmr_lock_ctl #(
    .IDXW (IDXW)
  ) u_lock (
    .clk_i      (CORE_CLK_I),
    .rst_i      (RST_I),
    .cs_rd_i    (cs_rd),
    .rd_idx_i   (acc_idx),
    .lockable_i (lockable),
    .frt_rd_i   (frt_rd),
    .cs_wr_i    (cs_wr),
    .wr_idx_i   (acc_idx),
    .lock_vld_o (lock_vld),
    .lock_idx_o (lock_idx)
  );

  // Slot array and scan engine
  always_comb begin
    for (int i = 0; i < NUM_MB; i++) begin
      nxt_code[i] = code_ff[i];
      nxt_len[i]  = len_ff[i];
      nxt_ts[i]   = ts_ff[i];
      nxt_id[i]   = id_ff[i];
      nxt_pay[i]  = pay_ff[i];
    end
    nxt_state     = state_ff;
    nxt_idx       = idx_ff;
    nxt_cand      = cand_ff;
    nxt_cand_vld  = cand_vld_ff;
    nxt_cand_free = cand_free_ff;
    nxt_cnt       = cnt_ff;
    nxt_deact     = dv;
    nxt_stg_id    = stg_id_ff;
    nxt_stg_len   = stg_len_ff;
    nxt_stg_pay   = stg_pay_ff;
    nxt_tx_vld    = tx_vld_ff;
    nxt_tx_late   = tx_late_ff;
    flag_set      = '0;
    if (WR_I && in_slot) begin
      case (ADDR_I[3:2])
        WD_CS: begin
          nxt_code[acc_idx] = WR_DATA_I[CS_CODE_LSB +: 4];
          nxt_len[acc_idx]  = WR_DATA_I[CS_LEN_LSB +: LEN_W];
        end
        WD_ID: nxt_id[acc_idx] = WR_DATA_I[ID_W-1:0];
        WD_D0: nxt_pay[acc_idx][PAY_W-1:DATA_W] = WR_DATA_I;
        default: nxt_pay[acc_idx][DATA_W-1:0] = WR_DATA_I;
      endcase
    end
    case (state_ff)
      ST_IDLE: begin
        if (RX_VALID_I && !(RX_SELF_I && mcr_ff[MCR_SRX_BIT])) begin
          nxt_stg_id   = RX_ID_I;
          nxt_stg_len  = RX_LEN_I;
          nxt_stg_pay  = RX_DATA_I;
          nxt_idx      = '0;
          nxt_cand_vld = 1'b0;
          nxt_deact    = '0;
          nxt_state    = ST_RSCAN;
        end else if (TX_REQ_I && !RX_VALID_I) begin
          nxt_idx      = '0;
          nxt_cand_vld = 1'b0;
          nxt_deact    = '0;
          nxt_state    = ST_TSCAN;
        end
      end
      ST_RSCAN: begin
        if (cand_vld_ff && dv[cand_ff]) begin
          nxt_cand_vld = 1'b0;
        end
        if (scan_hit && (!nxt_cand_vld || (!cand_free_ff &&
            code_ff[idx_ff] == CODE_RX_EMPTY))) begin
          nxt_cand      = idx_ff;
          nxt_cand_vld  = 1'b1;
          nxt_cand_free = code_ff[idx_ff] == CODE_RX_EMPTY;
        end
        nxt_idx = idx_ff + IDXW'(1);
        if (scan_last) begin
          nxt_cnt = '0;
          if (!nxt_cand_vld) begin
            nxt_state = ST_IDLE;
          end else if (lock_vld && lock_idx == nxt_cand) begin
            nxt_state = ST_RWAIT;
          end else begin
            nxt_state = ST_MOVE;
          end
        end
      end
      ST_RWAIT: begin
        if (RX_VALID_I && !(RX_SELF_I && mcr_ff[MCR_SRX_BIT])) begin
          nxt_stg_id   = RX_ID_I;
          nxt_stg_len  = RX_LEN_I;
          nxt_stg_pay  = RX_DATA_I;
          nxt_idx      = '0;
          nxt_cand_vld = 1'b0;
          nxt_deact    = '0;
          nxt_state    = ST_RSCAN;
        end else if (dv[cand_ff]) begin
          nxt_state = ST_IDLE;
        end else if (!(lock_vld && lock_idx == cand_ff)) begin
          nxt_state = ST_MOVE;
        end
      end
      ST_MOVE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (dv[cand_ff]) begin
          nxt_state = ST_IDLE;
        end else if (cnt_ff == 4'(MOVE_CYC - 1)) begin
          nxt_id[cand_ff]   = stg_id_ff;
          nxt_len[cand_ff]  = stg_len_ff;
          nxt_pay[cand_ff]  = stg_pay_ff;
          nxt_ts[cand_ff]   = frt_ff;
          nxt_code[cand_ff] = cand_free_ff ? CODE_RX_FULL : CODE_RX_OVERRUN;
          flag_set[cand_ff] = 1'b1;
          nxt_state         = ST_IDLE;
        end
      end
      ST_TSCAN: begin
        if (cand_vld_ff && dv[cand_ff]) begin
          nxt_cand_vld = 1'b0;
        end
        if (tx_active(code_ff[idx_ff]) && !dv[idx_ff] &&
            (!nxt_cand_vld || id_ff[idx_ff] < id_ff[cand_ff])) begin
          nxt_cand     = idx_ff;
          nxt_cand_vld = 1'b1;
        end
        nxt_idx = idx_ff + IDXW'(1);
        if (scan_last) begin
          nxt_tx_vld  = nxt_cand_vld;
          nxt_tx_late = 1'b0;
          nxt_state   = nxt_cand_vld ? ST_TOUT : ST_IDLE;
        end
      end
      ST_TOUT: begin
        if (dv[cand_ff]) begin
          nxt_tx_late = 1'b1;
        end
        if (TX_DONE_I) begin
          nxt_tx_vld = 1'b0;
          nxt_state  = ST_IDLE;
          if (!nxt_tx_late) begin
            nxt_code[cand_ff] = CODE_TX_INACTIVE;
            nxt_ts[cand_ff]   = frt_ff;
            flag_set[cand_ff] = 1'b1;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_MB; i++) begin
        code_ff[i] <= CODE_RX_INACTIVE;
        len_ff[i]  <= '0;
        ts_ff[i]   <= '0;
        id_ff[i]   <= '0;
        pay_ff[i]  <= '0;
      end
      state_ff     <= ST_IDLE;
      idx_ff       <= '0;
      cand_ff      <= '0;
      cand_vld_ff  <= 1'b0;
      cand_free_ff <= 1'b0;
      cnt_ff       <= '0;
      deact_ff     <= '0;
      stg_id_ff    <= '0;
      stg_len_ff   <= '0;
      stg_pay_ff   <= '0;
      tx_vld_ff    <= 1'b0;
      tx_late_ff   <= 1'b0;
      TX_ID_O      <= '0;
      TX_LEN_O     <= '0;
      TX_DATA_O    <= '0;
    end else begin
      for (int i = 0; i < NUM_MB; i++) begin
        code_ff[i] <= nxt_code[i];
        len_ff[i]  <= nxt_len[i];
        ts_ff[i]   <= nxt_ts[i];
        id_ff[i]   <= nxt_id[i];
        pay_ff[i]  <= nxt_pay[i];
      end
      state_ff     <= nxt_state;
      idx_ff       <= nxt_idx;
      cand_ff      <= nxt_cand;
      cand_vld_ff  <= nxt_cand_vld;
      cand_free_ff <= nxt_cand_free;
      cnt_ff       <= nxt_cnt;
      deact_ff     <= nxt_deact;
      stg_id_ff    <= nxt_stg_id;
      stg_len_ff   <= nxt_stg_len;
      stg_pay_ff   <= nxt_stg_pay;
      tx_vld_ff    <= nxt_tx_vld;
      tx_late_ff   <= nxt_tx_late;
      if (state_ff == ST_TSCAN && scan_last) begin
        TX_ID_O   <= id_ff[nxt_cand];
        TX_LEN_O  <= len_ff[nxt_cand];
        TX_DATA_O <= pay_ff[nxt_cand];
      end
    end
  end

  // Configuration, flags, timer and read data
  always_comb begin
    nxt_mcr     = mcr_ff;
    nxt_mask    = mask_ff;
    nxt_imask   = imask_ff;
    nxt_flag    = flag_ff;
    nxt_pop     = 1'b0;
    nxt_rd_data = '0;
    if (WR_I) begin
      case (ADDR_I)
        MCR_OFS: begin
          nxt_mcr[MCR_SRX_BIT] = WR_DATA_I[MCR_SRX_BIT];
          nxt_mcr[MCR_FRZ_BIT] = WR_DATA_I[MCR_FRZ_BIT];
          if (mcr_ff[MCR_FRZ_BIT]) begin
            nxt_mcr[MCR_RXQ_BIT] = WR_DATA_I[MCR_RXQ_BIT];
          end
        end
        MASK_OFS: nxt_mask = WR_DATA_I[ID_W-1:0];
        IMASK_OFS: nxt_imask = WR_DATA_I[NUM_MB-1:0];
        FLAG_OFS: begin
          nxt_flag = flag_ff & ~WR_DATA_I[NUM_MB-1:0];
          nxt_pop  = mcr_ff[MCR_RXQ_BIT] && flag_ff[RXQ_FLAG_BIT]
                     && WR_DATA_I[RXQ_FLAG_BIT];
        end
        default: nxt_mcr = mcr_ff;
      endcase
    end
    nxt_flag = nxt_flag | flag_set;
    if (RD_I) begin
      if (in_slot) begin
        case (ADDR_I[3:2])
          WD_CS: nxt_rd_data = {4'h0, acc_code, 4'h0, len_ff[acc_idx], ts_ff[acc_idx]};
          WD_ID: nxt_rd_data = {3'h0, id_ff[acc_idx]};
          WD_D0: nxt_rd_data = pay_ff[acc_idx][PAY_W-1:DATA_W];
          default: nxt_rd_data = pay_ff[acc_idx][DATA_W-1:0];
        endcase
      end else begin
        case (ADDR_I)
          MCR_OFS: nxt_rd_data = {29'h0000_0000, mcr_ff};
          FRT_OFS: nxt_rd_data = {16'h0000, frt_ff};
          MASK_OFS: nxt_rd_data = {3'h0, mask_ff};
          FLAG_OFS: nxt_rd_data = DATA_W'(flag_ff);
          IMASK_OFS: nxt_rd_data = DATA_W'(imask_ff);
          default: nxt_rd_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mcr_ff     <= MCR_RST;
      mask_ff    <= MASK_RST;
      imask_ff   <= '0;
      flag_ff    <= '0;
      frt_ff     <= '0;
      rd_data_ff <= '0;
      irq_ff     <= 1'b0;
      pop_ff     <= 1'b0;
    end else begin
      mcr_ff     <= nxt_mcr;
      mask_ff    <= nxt_mask;
      imask_ff   <= nxt_imask;
      flag_ff    <= nxt_flag;
      frt_ff     <= frt_ff + 16'h0001;
      rd_data_ff <= nxt_rd_data;
      irq_ff     <= |(nxt_flag & nxt_imask);
      pop_ff     <= nxt_pop;
    end
  end

  assign RD_DATA_O  = rd_data_ff;
  assign IRQ_O      = irq_ff;
  assign TX_VALID_O = tx_vld_ff;
  assign RXQ_EN_O   = mcr_ff[MCR_RXQ_BIT];
  assign RXQ_POP_O  = pop_ff;

endmodule

//--- cmr_mailbox_rx_checker.sv
// Port checker of the receive mailbox block
// Assumes the top module's ports and one core clock
`timescale 1ns/10ps
module cmr_mailbox_rx_checker
  import cmr_pkg::*;
(
  input wire logic                       CORE_CLK_I,
  input wire logic                       RST_I,
  input wire logic [cmr_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic                       WR_I,
  input wire logic                       RD_I,
  input wire logic [cmr_pkg::DATA_W-1:0] RD_DATA_O,
  input wire logic                       TX_REQ_I,
  input wire logic                       TX_DONE_I,
  input wire logic                       TX_VALID_O,
  input wire logic [cmr_pkg::ID_W-1:0]   TX_ID_O,
  input wire logic                       IRQ_O,
  input wire logic                       RXQ_EN_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  chk_rd_quiet: assert property (!$past(RD_I) |-> RD_DATA_O == 32'h0000_0000)
    else $error("read data outside read cycle");
  chk_timer_high: assert property (RD_I && ADDR_I == FRT_OFS |=> RD_DATA_O[31:16] == 16'h0000)
    else $error("timer read upper half not zero");
  chk_timer_step: assert property (RD_I && ADDR_I == FRT_OFS ##1 RD_I && ADDR_I == FRT_OFS
    |=> RD_DATA_O[15:0] == $past(RD_DATA_O[15:0]) + 16'h0001)
    else $error("timer did not advance by one");
  chk_tx_hold: assert property (TX_VALID_O && !TX_DONE_I |=> TX_VALID_O && $stable(TX_ID_O))
    else $error("transmit frame not held");
  chk_tx_drop: assert property (TX_VALID_O && TX_DONE_I |=> !TX_VALID_O)
    else $error("transmit valid not dropped after done");
  chk_tx_scan: assert property (TX_REQ_I && !TX_VALID_O |=> !TX_VALID_O [*8])
    else $error("transmit winner before scan end");
  chk_rxq_guard: assert property ($rose(RXQ_EN_O) |->
    $past(WR_I) && $past(ADDR_I) == MCR_OFS || $past(WR_I, 2) && $past(ADDR_I, 2) == MCR_OFS)
    else $error("queue enable rose without config write");
  chk_rst_quiet: assert property ($fell(RST_I) |-> !IRQ_O && !TX_VALID_O && !RXQ_EN_O)
    else $error("outputs active after reset");
endmodule

bind cmr_mailbox_rx cmr_mailbox_rx_checker u_chk (
  .CORE_CLK_I, .RST_I, .ADDR_I, .WR_I, .RD_I, .RD_DATA_O, .TX_REQ_I, .TX_DONE_I,
  .TX_VALID_O, .TX_ID_O, .IRQ_O, .RXQ_EN_O
);

//--- cmr_can_engine_model.sv
// Protocol engine stand-in: hands in frames, starts and ends transmissions
// Assumes the core clock; the bench spaces the frames
`timescale 1ns/10ps
module cmr_can_engine_model
  import cmr_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      tx_valid_i,
  output logic                           rx_valid_o = 1'b0,
  output logic      [cmr_pkg::ID_W-1:0]  rx_id_o = '0,
  output logic      [cmr_pkg::LEN_W-1:0] rx_len_o = '0,
  output logic      [cmr_pkg::PAY_W-1:0] rx_data_o = '0,
  output logic                           rx_self_o = 1'b0,
  output logic                           tx_req_o = 1'b0,
  output logic                           tx_done_o = 1'b0
);
  int sd = 73;

  // One-cycle frame, then released lines show the inverse
  task automatic send(input logic [ID_W-1:0] id, input logic [LEN_W-1:0] l,
                      input logic [PAY_W-1:0] d, input logic s);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_len_o <= l;
    rx_data_o <= d;
    rx_self_o <= s;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_len_o <= ~l;
    rx_data_o <= ~d;
    rx_self_o <= ~s;
  endtask

  task automatic txreq();
    @(posedge clk_i);
    tx_req_o <= 1'b1;
    @(posedge clk_i);
    tx_req_o <= 1'b0;
  endtask

  // Prompt or slow end of transmission
  initial forever begin
    @(posedge clk_i);
    if (tx_valid_i === 1'b1) begin
      repeat ($random(sd) & 7) @(posedge clk_i);
      tx_done_o <= 1'b1;
      @(posedge clk_i);
      tx_done_o <= 1'b0;
      @(posedge clk_i);
    end
  end
endmodule

//--- cmr_mailbox_rx_bench.sv
// Self-checking bench of the receive mailbox block
// Assumes the engine model on the frame side and seed 73
`timescale 1ns/10ps
module cmr_mailbox_rx_bench;
  import cmr_pkg::*;
  logic              clk = 0;
  logic              rst = 1;
  logic              wr = 0;
  logic              rd = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wd = '0;
  logic [DATA_W-1:0] rdat, v, q;
  logic              rxv, rxs, txr, txd, txv, irq, rxq, pop, bsy;
  logic [ID_W-1:0]   rxid, txid, id, tid;
  logic [LEN_W-1:0]  rxl, txl, l;
  logic [PAY_W-1:0]  rxd, txdat, p;
  logic [15:0]       t0;
  int                error_cnt = 0;
  int                num_checks = 0;
  int                seed = 73;

  always #12.5 clk = ~clk;

  cmr_mailbox_rx DUT (
    .CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(adr), .WR_DATA_I(wd), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdat), .RX_VALID_I(rxv), .RX_ID_I(rxid), .RX_LEN_I(rxl), .RX_DATA_I(rxd),
    .RX_SELF_I(rxs), .TX_REQ_I(txr), .TX_DONE_I(txd), .TX_VALID_O(txv), .TX_ID_O(txid),
    .TX_LEN_O(txl), .TX_DATA_O(txdat), .IRQ_O(irq), .RXQ_EN_O(rxq), .RXQ_POP_O(pop));
  cmr_can_engine_model eng (
    .clk_i(clk), .tx_valid_i(txv), .rx_valid_o(rxv), .rx_id_o(rxid), .rx_len_o(rxl),
    .rx_data_o(rxd), .rx_self_o(rxs), .tx_req_o(txr), .tx_done_o(txd));

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] sa(input int n, input int w);
    return SLOT_BASE + ADDR_W'(n * 16 + w * 4);
  endfunction

  task automatic wg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask

  task automatic rg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd <= 1;
    adr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdat;
  endtask

  // Absence waits out a full round first, presence polls with a bound
  task automatic wfl(input int n, input logic e);
    int i;
    i = 0;
    if (!e) repeat (60) @(posedge clk);
    do begin
      rg(FLAG_OFS, v);
      i++;
    end while (v[n] !== e && i < 40);
    chk("flag", v[n], e);
  endtask

  task automatic fr(input logic s);
    p = {$random(seed), $random(seed)};
    l = 4'(($random(seed) & 7) + 1);
    eng.send(id, l, p, s);
  endtask

  task automatic stamp();
    rg(FRT_OFS, v);
    t0 = v[15:0];
  endtask

  task automatic rxc(input int n, input logic [3:0] c);
    rg(sa(n, 0), v);
    chk("code", v[27:24], c);
    chk("len", v[19:16], l);
    chk("stamp", 16'(v[15:0] - t0) < 16'd60, 1);
    rg(sa(n, 1), v);
    chk("id", v[28:0], id);
    rg(sa(n, 2), v);
    chk("d0", v, p[63:32]);
    rg(sa(n, 3), v);
    chk("d1", v, p[31:0]);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rg(MCR_OFS, v);
    chk("cfg", v, 32'h0000_0004);
    rg(MASK_OFS, v);
    chk("mask", v[28:0], MASK_RST);
    rg(sa(1, 0), v);
    chk("idle", v[27:24], CODE_RX_INACTIVE);
    rg(12'h004, v);
    chk("unmapped", v, 0);
    id = 29'($random(seed));
    for (int n = 1; n < 4; n += 2) begin
      wg(sa(n, 1), 32'(id));
      wg(sa(n, 0), 32'h0400_0000);
    end
    wg(IMASK_OFS, 32'h0000_001E);
    wg(MASK_OFS, 32'h1FFF_FFFE);
    id[0] = ~id[0];
    stamp();
    fr(0);
    wfl(1, 1);
    chk("irq", irq, 1);
    rxc(1, CODE_RX_FULL);
    q = p[63:32];
    stamp();
    fr(0);
    bsy = 0;
    repeat (16) begin
      rg(sa(3, 0), v);
      bsy |= v[24];
    end
    chk("busy", bsy, 1);
    wfl(3, 1);
    rxc(3, CODE_RX_FULL);
    wg(FLAG_OFS, 32'h0000_000A);
    repeat (3) @(posedge clk);
    chk("irq", irq, 0);
    wg(MCR_OFS, 32'h0000_0005);
    fr(1);
    wfl(1, 0);
    wg(MCR_OFS, 32'h0000_0004);
    rg(sa(1, 0), v);
    fr(0);
    wfl(1, 0);
    rg(sa(1, 2), v);
    chk("held", v, q);
    fr(0);
    repeat (20) @(posedge clk);
    stamp();
    wfl(1, 1);
    rxc(1, CODE_RX_OVERRUN);
    wg(FLAG_OFS, 32'h0000_0002);
    q = p[63:32];
    fr(0);
    repeat (30) @(posedge clk);
    wg(sa(1, 0), 32'h0400_0000);
    wfl(1, 0);
    rg(sa(1, 2), v);
    chk("cancel", v, q);
    stamp();
    fr(0);
    wfl(1, 1);
    @(posedge clk);
    rd <= 1;
    adr <= FRT_OFS;
    repeat (2) @(posedge clk);
    rd <= 0;
    tid = 29'($random(seed));
    tid[0] = 0;
    wg(sa(2, 1), 32'(tid | 29'h1));
    wg(sa(4, 1), 32'(tid));
    wg(sa(4, 2), 32'(tid));
    wg(sa(2, 0), 32'h0C08_0000);
    wg(sa(4, 0), 32'h0C08_0000);
    eng.txreq();
    for (int i = 0; i < 60 && txv !== 1'b1; i++) @(posedge clk);
    chk("txid", txid, tid);
    chk("txlen", txl, 4'h8);
    chk("txdata", txdat, {32'(tid), 32'h0000_0000});
    for (int i = 0; i < 30 && txv !== 1'b0; i++) @(posedge clk);
    wfl(4, 1);
    rg(sa(4, 0), v);
    chk("txcode", v[27:24], CODE_TX_INACTIVE);
    wg(MCR_OFS, 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk("rxq", rxq, 1);
    wg(sa(5, 1), 32'(id));
    wg(sa(5, 0), 32'h0400_0000);
    fr(0);
    wfl(5, 1);
    wg(FLAG_OFS, 32'h0000_0020);
    #1 chk("pop", pop, 1);
    wg(MCR_OFS, 32'h0000_0000);
    wg(MCR_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("rxq", rxq, 0);
    wrap_up();
  end

endmodule
